// ### rtl/tbs_pkg.sv
// Constants, types and helpers for the transmit burst sequencer
// Summary of operation
// - Sample tick every half symbol period
// - Burst go sampled on tick falling edge
// - Hold zero 9.5 ticks plus offset
// - Amplifier enable rises with ramp start
// - First point six ticks after ramp
// - Shift word right per tick, LSB first
// - Last point 15.5 ticks after last symbol
// - Zero and amplifier off six ticks later
// - Offset adds quarter-tick steps, 0 to 3
// - Offset shifts amplifier and waveform equally
// - Digital mode: encode, ramp, fixed level
// - Analog mode: outputs follow written samples
// - Burst length follows burst go duration
// - Mode one digital, zero analog
// - Analog mode keeps amplifier enable high
package tbs_pkg;

  // Clock and tick timing
  localparam int CLK_HZ  = 100_000_000;
  localparam int SYM_HZ  = 24_300;
  localparam int TICK_HZ = 2 * SYM_HZ;
  localparam int QTR_CYC = CLK_HZ / (4 * TICK_HZ);
  localparam int QCNT_W  = 10;
  localparam logic [QCNT_W-1:0] QTR_LAST = QCNT_W'(QTR_CYC - 1);
  localparam logic [1:0] IRQ_FALL_PH = 2'h2;

  // Burst timing in quarter ticks
  localparam int HOLD_Q     = 38;
  localparam int RAMP_Q     = 24;
  localparam int POINT_Q    = 62;
  localparam int LAST_SYM_Q = 8;
  localparam int SYM_LAG_Q  = 5;
  localparam int TIMER_W    = 7;
  localparam logic [TIMER_W-1:0] HOLD_END  = TIMER_W'(HOLD_Q);
  localparam logic [TIMER_W-1:0] TAIL_END  = TIMER_W'(POINT_Q - LAST_SYM_Q);
  localparam logic [TIMER_W-1:0] DLY_BASE  = TIMER_W'(POINT_Q - SYM_LAG_Q);
  localparam logic [4:0]         LEVEL_TOP = 5'(RAMP_Q);
  localparam logic signed [15:0] RAMP_DIV  = 16'sh0018;

  // Data path sizes
  localparam int WORD_BITS  = 10;
  localparam int FIFO_DEPTH = 8;
  localparam int DLY_DEPTH  = 128;

  // Constellation amplitudes
  localparam logic signed [7:0] PT_RADIUS = 8'sh60;
  localparam logic signed [7:0] PT_DIAG   = 8'sh44;

  // Phase steps in units of pi/4 per dibit
  localparam logic [2:0] STEP_00 = 3'h1;
  localparam logic [2:0] STEP_01 = 3'h3;
  localparam logic [2:0] STEP_11 = 3'h5;
  localparam logic [2:0] STEP_10 = 3'h7;

  typedef enum logic [2:0] {ST_IDLE, ST_HOLD, ST_RAMP, ST_BURST, ST_TAIL, ST_DECAY} tbsState_e;

  typedef struct packed {
    logic [2:0]           dibits;
    logic [WORD_BITS-1:0] bits;
  } tbsWord_s;

  typedef struct packed {
    logic signed [7:0] i;
    logic signed [7:0] q;
  } tbsSample_s;

  // In-phase coordinate of a constellation phase
  function automatic logic signed [7:0] tbs_point_i(input logic [2:0] ph);
    logic signed [7:0] v;
    v = 8'sh00;
    unique case (ph)
      3'h0: v = PT_RADIUS;
      3'h1: v = PT_DIAG;
      3'h2: v = 8'sh00;
      3'h3: v = -PT_DIAG;
      3'h4: v = -PT_RADIUS;
      3'h5: v = -PT_DIAG;
      3'h6: v = 8'sh00;
      3'h7: v = PT_DIAG;
    endcase
    return v;
  endfunction

  // Ramp scaling of a coordinate by the envelope level
  function automatic logic signed [7:0] tbs_scale(input logic signed [7:0] pt,
                                                  input logic [4:0] lvl);
    logic signed [15:0] p;
    p = 16'(pt * $signed({1'b0, lvl}));
    return 8'(p / RAMP_DIV);
  endfunction

endpackage

// ### rtl/tbs_fifo.sv
// Word FIFO between DSP writes and the bit shifter
`timescale 1ns/1ns
`default_nettype none
module tbs_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Filling side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // Draining side
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wPtr;
    logic [AW-1:0] rPtr;
    logic [AW:0]   count;
  } tbsFifo_s;

  tbsFifo_s         s;
  tbsFifo_s         next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  // Honest full and empty from the occupancy count
  assign inReady  = (s.count != FULL_CNT);
  assign outValid = (s.count != '0);
  assign outData  = mem[s.rPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // Pointer and count update
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.wPtr = s.wPtr + 1'b1;
    end
    if (pop) begin
      next_s.rPtr = s.rPtr + 1'b1;
    end
    next_s.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Storage array
  always_ff @(posedge clk) begin
    if (push) begin
      mem[s.wPtr] <= inData;
    end
  end
endmodule
`default_nettype wire

// ### rtl/tbs_dqpsk_encoder.sv
// Differential pi/4 phase encoder for dibits
`timescale 1ns/1ns
`default_nettype none
module tbs_dqpsk_encoder
  import tbs_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Control
  input  wire logic       clear,
  input  wire logic       step,
  input  wire logic [1:0] dibit,
  // Current phase in units of pi/4
  output logic [2:0]      phase
);
  typedef struct packed {
    logic [2:0] phase;
  } tbsEnc_s;

  tbsEnc_s    s;
  tbsEnc_s    next_s;
  logic [2:0] delta;

  // Dibit to phase change map
  always_comb begin
    delta = STEP_00;
    unique case (dibit)
      2'h0: delta = STEP_00;
      2'h1: delta = STEP_01;
      2'h3: delta = STEP_11;
      2'h2: delta = STEP_10;
    endcase
  end

  // Phase holds between symbols, advances on a step
  always_comb begin
    next_s = s;
    if (clear) begin
      next_s.phase = 3'h0;
    end else if (step) begin
      next_s.phase = s.phase + delta;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign phase = s.phase;

  property p_enc_step;
    @(posedge clk) disable iff (!rstn)
    (step && !clear) |=> (phase == 3'($past(phase) + $past(delta)));
  endproperty
  a_enc_step: assert property (p_enc_step) else $error("phase step wrong");

  property p_enc_hold;
    @(posedge clk) disable iff (!rstn)
    (!step && !clear) |=> $stable(phase);
  endproperty
  a_enc_hold: assert property (p_enc_hold) else $error("phase not held");
endmodule
`default_nettype wire

// ### rtl/tbs_burst_sequencer.sv
// Transmit burst sequencer: tick pacing, burst timing, ramp and output mux
`timescale 1ns/1ns
`default_nettype none
module tbs_burst_sequencer
  import tbs_pkg::*;
(
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst_b,
  // DSP control bits
  input  wire logic          modeDigital,
  input  wire logic          burstGo,
  input  wire logic [1:0]    burstDelayOffset,
  // Burst data words
  input  wire tbs_pkg::tbsWord_s inphaseTxWord,
  input  wire logic          inphaseTxValid,
  output logic               inphaseTxReady,
  // Analog samples
  input  wire logic [7:0]    analogInphase,
  input  wire logic [7:0]    quadratureTxWord,
  input  wire logic          analogWrite,
  // Outputs
  output logic               sampleTickIrq,
  output tbs_pkg::tbsSample_s txOut,
  output logic               ampEnableOut,
  output logic               burstActive
);
  typedef struct packed {
    logic                 goMeta;
    logic                 goSync;
    logic [QCNT_W-1:0]    qCnt;
    logic [1:0]           qPhase;
    logic                 irq;
    tbsState_e            state;
    logic [TIMER_W-1:0]   timer;
    logic [1:0]           dLatch;
    logic [4:0]           level;
    logic [WORD_BITS-1:0] curBits;
    logic [3:0]           curLeft;
    logic                 firstBit;
    logic                 bitOdd;
    tbsSample_s           tx;
    logic                 amp;
    logic [TIMER_W-1:0]   wPtr;
  } tbsSeq_s;

  tbsSeq_s            s;
  tbsSeq_s            next_s;
  logic [1:0]         rstSync;
  logic               rstn;
  logic               qEn;
  logic               fallEn;
  logic [1:0]         qNext;
  logic               fifoValid;
  tbsWord_s           fifoWord;
  logic               fifoPop;
  logic               encClear;
  logic               encStep;
  logic [1:0]         encDibit;
  logic [2:0]         encPhase;
  logic [2:0]         phaseLine [DLY_DEPTH];
  logic [TIMER_W-1:0] rdPtr;
  logic [2:0]         outPhase;
  logic               bitNow;
  logic               consume;
  logic               goHigh;

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstn = rstSync[1];

  // Data word buffer
  tbs_fifo #(
    .WIDTH ($bits(tbsWord_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (core_clk),
    .rstn     (rstn),
    .inValid  (inphaseTxValid),
    .inData   (inphaseTxWord),
    .inReady  (inphaseTxReady),
    .outValid (fifoValid),
    .outData  (fifoWord),
    .outReady (fifoPop)
  );

  // Symbol phase encoder
  tbs_dqpsk_encoder u_enc (
    .clk   (core_clk),
    .rstn  (rstn),
    .clear (encClear),
    .step  (encStep),
    .dibit (encDibit),
    .phase (encPhase)
  );

  // Quarter-tick pacing and tick falling edge
  assign qEn    = (s.qCnt == QTR_LAST);
  assign qNext  = s.qPhase + 2'h1;
  assign fallEn = qEn && (qNext == IRQ_FALL_PH);
  assign goHigh = s.goSync;

  // Delayed phase tap, offset adds quarter ticks; reference phase until burst data arrives
  assign rdPtr    = s.wPtr - DLY_BASE - TIMER_W'(s.dLatch);
  assign outPhase = (s.state inside {ST_IDLE, ST_HOLD, ST_RAMP}) ? 3'h0 : phaseLine[rdPtr];

  // Next bit from the word, least significant first
  always_comb begin
    bitNow = 1'b0;
    if (s.curLeft != 4'h0) begin
      bitNow = s.curBits[0];
    end else if (fifoValid) begin
      bitNow = fifoWord.bits[0];
    end
  end

  // Sequencer next-state
  always_comb begin
    next_s   = s;
    encClear = 1'b0;
    encStep  = 1'b0;
    encDibit = 2'h0;
    fifoPop  = 1'b0;
    consume  = 1'b0;
    next_s.goMeta = burstGo;
    next_s.goSync = s.goMeta;
    next_s.qCnt   = qEn ? '0 : s.qCnt + 1'b1;
    if (qEn) begin
      next_s.qPhase = qNext;
      next_s.irq    = ~qNext[1];
      next_s.timer  = s.timer + 1'b1;
      next_s.wPtr   = s.wPtr + 1'b1;
    end
    if (!modeDigital) begin
      // Analog mode: samples pass straight, amplifier stays on
      next_s.state   = ST_IDLE;
      next_s.amp     = 1'b1;
      next_s.level   = 5'h0;
      next_s.curLeft = 4'h0;
      encClear       = 1'b1;
      if (analogWrite) begin
        next_s.tx.i = analogInphase;
        next_s.tx.q = quadratureTxWord;
      end
    end else begin
      // Digital mode envelope and output, fixed ramp only
      next_s.tx.i = tbs_scale(tbs_point_i(outPhase), s.level);
      next_s.tx.q = tbs_scale(tbs_point_i(outPhase - 3'h2), s.level);
      unique case (s.state)
        ST_IDLE: begin
          next_s.amp     = 1'b0;
          next_s.level   = 5'h0;
          next_s.curLeft = 4'h0;
          next_s.bitOdd  = 1'b0;
          encClear       = 1'b1;
          if (fallEn && goHigh) begin
            next_s.state  = ST_HOLD;
            next_s.timer  = '0;
            next_s.dLatch = burstDelayOffset;
            consume       = 1'b1;
          end
        end
        ST_HOLD: begin
          if (qEn && next_s.timer == HOLD_END + TIMER_W'(s.dLatch)) begin
            next_s.state = ST_RAMP;
            next_s.amp   = 1'b1;
          end
        end
        ST_RAMP: begin
          if (qEn) begin
            next_s.level = s.level + 5'h1;
            if (next_s.level == LEVEL_TOP) begin
              next_s.state = ST_BURST;
            end
          end
        end
        ST_BURST: begin
          next_s.level = LEVEL_TOP;
        end
        ST_TAIL: begin
          if (qEn && next_s.timer == TAIL_END + TIMER_W'(s.dLatch)) begin
            next_s.state = (s.level == 5'h0) ? ST_IDLE : ST_DECAY;
            if (s.level == 5'h0) begin
              next_s.amp = 1'b0;
            end
          end
        end
        ST_DECAY: begin
          if (qEn) begin
            next_s.level = s.level - 5'h1;
            if (next_s.level == 5'h0) begin
              next_s.state = ST_IDLE;
              next_s.amp   = 1'b0;
            end
          end
        end
      endcase
      // Burst length set by burst go, sampled at tick fall
      if (fallEn && (s.state == ST_HOLD || s.state == ST_RAMP || s.state == ST_BURST)) begin
        if (goHigh) begin
          consume = 1'b1;
        end else begin
          next_s.state = ST_TAIL;
          next_s.timer = '0;
        end
      end
      // One bit per tick, two bits form a symbol
      if (consume) begin
        if (s.curLeft != 4'h0) begin
          next_s.curBits = s.curBits >> 1;
          next_s.curLeft = s.curLeft - 4'h1;
        end else if (fifoValid) begin
          fifoPop        = 1'b1;
          next_s.curBits = fifoWord.bits >> 1;
          next_s.curLeft = {fifoWord.dibits, 1'b0} - 4'h1;
        end
        if (!next_s.bitOdd) begin
          next_s.firstBit = bitNow;
          next_s.bitOdd   = 1'b1;
        end else begin
          encStep       = 1'b1;
          encDibit      = {s.firstBit, bitNow};
          next_s.bitOdd = 1'b0;
          encClear      = 1'b0;
        end
      end
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Phase delay line, one entry per quarter tick
  always_ff @(posedge core_clk) begin
    if (qEn) begin
      phaseLine[s.wPtr] <= encPhase;
    end
  end

  // Registered outputs; burst active decoded from the state register
  assign sampleTickIrq = s.irq;
  assign txOut         = s.tx;
  assign ampEnableOut  = s.amp;
  assign burstActive   = (s.state != ST_IDLE);

  // Checking aids
  localparam int TICK_CYC = 4 * QTR_CYC;
  logic [11:0] tickAge;
  logic        seenFall;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tickAge  <= 12'h000;
      seenFall <= 1'b0;
    end else if (s.irq && !next_s.irq) begin
      tickAge  <= 12'h000;
      seenFall <= 1'b1;
    end else begin
      tickAge  <= tickAge + 12'h001;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_tick_period;
    (seenFall && s.irq && !next_s.irq) |-> (tickAge == 12'(TICK_CYC - 1));
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick period wrong");

  property p_go_on_fall;
    ($past(s.state) == ST_IDLE && s.state == ST_HOLD) |-> ($past(fallEn) && $past(s.goSync));
  endproperty
  a_go_on_fall: assert property (p_go_on_fall) else $error("start not at fall");

  property p_hold_zero;
    (modeDigital && $past(modeDigital) && s.state == ST_HOLD)
      |-> (s.tx.i == 8'sh00 && s.tx.q == 8'sh00 && !s.amp);
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("output during hold");

  property p_ramp_start;
    ($past(s.state) == ST_HOLD && s.state == ST_RAMP)
      |-> (s.timer == HOLD_END + TIMER_W'(s.dLatch) && s.amp && s.level == 5'h0);
  endproperty
  a_ramp_start: assert property (p_ramp_start) else $error("ramp start timing");

  property p_amp_with_ramp;
    (modeDigital && $rose(s.amp)) |-> (s.state == ST_RAMP && $past(s.state) == ST_HOLD);
  endproperty
  a_amp_with_ramp: assert property (p_amp_with_ramp) else $error("amp not with ramp");

  property p_first_point;
    ($past(s.state) == ST_RAMP && s.state == ST_BURST)
      |-> (s.timer == HOLD_END + TIMER_W'(RAMP_Q) + TIMER_W'(s.dLatch));
  endproperty
  a_first_point: assert property (p_first_point) else $error("first point timing");

  property p_lsb_shift;
    (consume && s.curLeft != 4'h0 && modeDigital)
      |=> (s.curBits == ($past(s.curBits) >> 1));
  endproperty
  a_lsb_shift: assert property (p_lsb_shift) else $error("word not shifted");

  property p_decay_start;
    ($past(s.state) == ST_TAIL && s.state == ST_DECAY)
      |-> (s.timer == TAIL_END + TIMER_W'(s.dLatch));
  endproperty
  a_decay_start: assert property (p_decay_start) else $error("decay start timing");

  property p_amp_off_zero;
    (modeDigital && $past(modeDigital) && $fell(s.amp))
      |-> (s.level == 5'h0 && s.state == ST_IDLE) ##1 (s.tx.i == 8'sh00 && s.tx.q == 8'sh00);
  endproperty
  a_amp_off_zero: assert property (p_amp_off_zero) else $error("amp off not at zero");

  property p_analog_amp;
    (!modeDigital && !$past(modeDigital)) |-> (s.amp && s.state == ST_IDLE);
  endproperty
  a_analog_amp: assert property (p_analog_amp) else $error("analog amp low");

  property p_analog_pass;
    (!modeDigital && analogWrite)
      |=> (s.tx.i == $past(analogInphase) && s.tx.q == $past(quadratureTxWord));
  endproperty
  a_analog_pass: assert property (p_analog_pass) else $error("analog sample lost");
endmodule
`default_nettype wire

// ### tb/tbs_dsp_model.sv
// Behavioural DSP side: burst words, go and offset bits, analog samples
`timescale 1ns/1ns
`default_nettype none
module tbs_dsp_model
  import tbs_pkg::*;
(
  // Clock and status
  input  wire logic         core_clk,
  input  wire logic         inphaseTxReady,
  // Burst control
  output logic              burstGo,
  output logic [1:0]        burstDelayOffset,
  // Burst data words
  output tbs_pkg::tbsWord_s inphaseTxWord,
  output logic              inphaseTxValid,
  // Analog samples
  output logic [7:0]        analogInphase,
  output logic [7:0]        quadratureTxWord,
  output logic              analogWrite
);
  // Idle levels from time zero
  initial begin
    burstGo = 1'b0;
    burstDelayOffset = 2'h0;
    inphaseTxWord = '0;
    inphaseTxValid = 1'b0;
    analogInphase = 8'h00;
    quadratureTxWord = 8'h00;
    analogWrite = 1'b0;
  end

  // Offer a word after a random stall; hold it until taken or the wait runs out
  task automatic pushWord(input tbsWord_s w, input int lim, output bit taken);
    repeat ($urandom_range(1, 3)) @(negedge core_clk);
    inphaseTxWord = w;
    inphaseTxValid = 1'b1;
    for (int n = 0; n < lim && inphaseTxReady !== 1'b1; n++) begin
      @(negedge core_clk);
    end
    taken = (inphaseTxReady === 1'b1);
    @(negedge core_clk);
    inphaseTxValid = 1'b0;
    inphaseTxWord = ~w;  // Released word shows no stale value
  endtask

  // Offset settles before go moves; whole-tick delays come from write timing
  task automatic setGo(input logic go, input logic [1:0] d);
    @(negedge core_clk);
    burstDelayOffset = d;
    @(negedge core_clk);
    burstGo = go;
  endtask

  // One analog sample, slightly attenuated, strobed for one cycle
  task automatic writeSample(input logic [7:0] i, input logic [7:0] q);
    @(negedge core_clk);
    analogInphase = 8'($signed(i) - ($signed(i) >>> 4));
    quadratureTxWord = 8'($signed(q) - ($signed(q) >>> 4));
    analogWrite = 1'b1;
    @(negedge core_clk);
    analogWrite = 1'b0;
    analogInphase = ~analogInphase;
    quadratureTxWord = ~quadratureTxWord;
  endtask
endmodule
`default_nettype wire

// ### tb/tbs_burst_sequencer_tb.sv
// Self-checking bench for the transmit burst sequencer
`timescale 1ns/1ns
`default_nettype none
module tbs_burst_sequencer_tb;
  import tbs_pkg::*;

  localparam int QC = 514;  // Cycles per quarter tick

  logic       core_clk;
  logic       rst_b;
  logic       modeDigital;
  logic       burstGo;
  logic [1:0] burstDelayOffset;
  tbsWord_s   inphaseTxWord;
  logic       inphaseTxValid;
  logic       inphaseTxReady;
  logic [7:0] analogInphase;
  logic [7:0] quadratureTxWord;
  logic       analogWrite;
  logic       sampleTickIrq;
  tbsSample_s txOut;
  logic       ampEnableOut;
  logic       burstActive;
  logic       irqSeen;
  int         cyc = 0;
  int         lastFall = 0;
  int         errTotal = 0;
  int         nChecks = 0;

  tbs_burst_sequencer u_tbs_burst_sequencer (
    .core_clk         (core_clk),
    .rst_b            (rst_b),
    .modeDigital      (modeDigital),
    .burstGo          (burstGo),
    .burstDelayOffset (burstDelayOffset),
    .inphaseTxWord    (inphaseTxWord),
    .inphaseTxValid   (inphaseTxValid),
    .inphaseTxReady   (inphaseTxReady),
    .analogInphase    (analogInphase),
    .quadratureTxWord (quadratureTxWord),
    .analogWrite      (analogWrite),
    .sampleTickIrq    (sampleTickIrq),
    .txOut            (txOut),
    .ampEnableOut     (ampEnableOut),
    .burstActive      (burstActive)
  );

  tbs_dsp_model u_tbs_dsp_model (
    .core_clk         (core_clk),
    .inphaseTxReady   (inphaseTxReady),
    .burstGo          (burstGo),
    .burstDelayOffset (burstDelayOffset),
    .inphaseTxWord    (inphaseTxWord),
    .inphaseTxValid   (inphaseTxValid),
    .analogInphase    (analogInphase),
    .quadratureTxWord (quadratureTxWord),
    .analogWrite      (analogWrite)
  );

  // Clock and cycle count
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  // Last tick fall, seen between edges
  always @(negedge core_clk) begin
    if (irqSeen === 1'b1 && sampleTickIrq === 1'b0) begin
      lastFall = cyc;
    end
    irqSeen = sampleTickIrq;
  end

  // Verdict and end of run
  task automatic completeRun();
    $display("checks %0d mismatches %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Compare within a tolerance; zero means exact
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input int tol);
    logic ok;
    nChecks++;
    ok = (got + tol >= exp) && (got <= exp + tol);
    if (ok !== 1'b1) begin
      errTotal++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait for tick (0), active (1) or amplifier (2) level
  task automatic waitSig(input int sel, input logic lvl, input int lim);
    logic v;
    for (int n = 0; n <= lim; n++) begin
      v = (sel == 0) ? sampleTickIrq : (sel == 1) ? burstActive : ampEnableOut;
      if (v === lvl) return;
      @(negedge core_clk);
    end
    errTotal++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, v, lvl);
    completeRun();
  endtask

  // Phase step per dibit in eighths of a turn
  function automatic logic [2:0] step(input logic [1:0] b);
    case (b)
      2'h0: step = 3'h1;
      2'h1: step = 3'h3;
      2'h3: step = 3'h5;
      default: step = 3'h7;
    endcase
  endfunction

  // Cosine coordinate of a phase; sine is the phase less a quarter turn
  function automatic logic [7:0] coord(input logic [2:0] ph);
    case (ph)
      3'h0: coord = PT_RADIUS;
      3'h4: coord = -PT_RADIUS;
      3'h1, 3'h7: coord = PT_DIAG;
      3'h3, 3'h5: coord = -PT_DIAG;
      default: coord = 8'h00;
    endcase
  endfunction

  // Expected analog sample after attenuation
  function automatic logic [7:0] atten(input logic [7:0] v);
    atten = v - {{4{v[7]}}, v[7:4]};
  endfunction

  // Main sequence
  initial begin
    tbsWord_s   w;
    logic [1:0] dib [9];
    logic [2:0] ph;
    logic [1:0] d;
    logic [7:0] ri;
    logic [7:0] rq;
    logic       zeroOk;
    bit         taken;
    int         t0;
    core_clk = 1'b0;
    rst_b = 1'b0;
    modeDigital = 1'b1;
    void'($urandom(81));
    repeat (8) @(negedge core_clk);
    check({ampEnableOut, burstActive, inphaseTxReady, txOut}, 19'h10000, 0);
    rst_b = 1'b1;
    repeat (4) @(negedge core_clk);
    // Tick high time and period; the first pulse after reset is short
    waitSig(0, 1'b1, 3000);
    waitSig(0, 1'b0, 3000);
    waitSig(0, 1'b1, 3000);
    t0 = cyc;
    waitSig(0, 1'b0, 3000);
    check(cyc - t0, 2 * QC, 0);
    waitSig(0, 1'b1, 3000);
    check(cyc - t0, 4 * QC, 0);
    $display("test tick_rate done");
    // Analog writes refused in digital mode, followed in analog mode
    u_tbs_dsp_model.writeSample(8'h5a, 8'ha5);
    check(txOut, 16'h0000, 0);
    modeDigital = 1'b0;
    repeat (3) @(negedge core_clk);
    check(ampEnableOut, 1'b1, 0);
    for (int k = 0; k < 4; k++) begin
      ri = 8'($urandom);
      rq = 8'($urandom);
      u_tbs_dsp_model.writeSample(ri, rq);
      check({txOut, ampEnableOut}, {atten(ri), atten(rq), 1'b1}, 0);
    end
    modeDigital = 1'b1;
    repeat (3) @(negedge core_clk);
    check({ampEnableOut, burstActive}, 2'h0, 0);
    $display("test analog_mode done");
    // Fill the word buffer until it refuses, one dibit per word
    for (int k = 0; k < 9; k++) begin
      w.dibits = 3'h1;
      w.bits = (k < 8) ? 10'($urandom) : 10'h3ff;
      dib[k] = (k < 8) ? {w.bits[0], w.bits[1]} : 2'h0;
      u_tbs_dsp_model.pushWord(w, (k < 8) ? 40 : 4, taken);
      check(taken, (k < 8), 0);
    end
    check(inphaseTxReady, 1'b0, 0);
    $display("test fifo_fill done");
    // One burst: hold, ramp, symbols, tail and decay
    d = 2'($urandom);
    u_tbs_dsp_model.setGo(1'b1, d);
    waitSig(1, 1'b1, 2200);
    t0 = cyc;
    @(negedge core_clk);
    check(t0, lastFall, 0);
    zeroOk = 1'b1;
    while (ampEnableOut !== 1'b1 && cyc < t0 + 43 * QC) begin
      if (txOut !== 16'h0000) zeroOk = 1'b0;
      @(negedge core_clk);
    end
    check(zeroOk, 1'b1, 0);
    check(cyc - t0, (38 + d) * QC, 3);
    ph = 3'h0;
    for (int k = 0; k < 9; k++) begin
      if (k == 2) begin
        while (cyc < t0 + 78 * QC) @(negedge core_clk);
        u_tbs_dsp_model.setGo(1'b0, d);
      end
      ph = ph + step(dib[k]);
      while (cyc < t0 + (66 + d + 8 * k) * QC) @(negedge core_clk);
      check(txOut, {coord(ph), coord(ph - 3'h2)}, 0);
    end
    waitSig(2, 1'b0, 90 * QC);
    check(cyc - t0, (158 + d) * QC, 3);
    @(negedge core_clk);
    check({txOut, burstActive, inphaseTxReady}, 18'h00001, 0);
    $display("test burst done");
    completeRun();
  end

  // Run-length guard
  initial begin
    repeat (96000) @(posedge core_clk);
    errTotal++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, cyc, 0);
    completeRun();
  end
endmodule
`default_nettype wire
